// [gms_map.vh]
`ifndef GMS_MAP_VH
`define GMS_MAP_VH
// ------------------------------------------------------------
// register indices
// ------------------------------------------------------------
`define GMS_IDX_MS_CTRL     5'h09
`define GMS_IDX_MS_STAT     5'h0A
`define GMS_IDX_MMD_CTRL    5'h0D
`define GMS_IDX_MMD_ADDAT   5'h0E
`define GMS_IDX_EXT_STAT    5'h0F
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define GMS_CTL_TEST_HI     15
`define GMS_CTL_TEST_LO     13
`define GMS_CTL_MAN_EN      12
`define GMS_CTL_MAN_MASTER  11
`define GMS_CTL_PORT_TYPE   10
`define GMS_CTL_ADV_FD      9
`define GMS_CTL_ADV_HD      8
`define GMS_MMD_FN_HI       15
`define GMS_MMD_FN_LO       14
`define GMS_MMD_DEV_HI      4
`define GMS_MMD_DEV_LO      0
// ------------------------------------------------------------
// reset values and codes
// ------------------------------------------------------------
`define GMS_CTL_RST         8'h02
`define GMS_TEST_MAX        3'h4
`define GMS_FN_ADDR         2'h0
`define GMS_FN_DATA         2'h1
`define GMS_FN_INC_RW       2'h2
`define GMS_FN_INC_WR       2'h3
`define GMS_IDLE_ERR_MAX    8'hFF
`define GMS_EXT_STAT_VAL    16'h2000
`endif

// [gms_mmd_model.sv]
`timescale 1ns/1ps
`default_nettype none
module gms_mmd_model (
	input wire logic        clock,
	input wire logic [4:0]  dev,
	input wire logic [15:0] addr,
	input wire logic        wr,
	input wire logic [15:0] wdata,
	output logic     [15:0] rdata
);
	logic [15:0] mem [256] = '{default: 16'h0000};
	assign rdata = mem[{dev[3:0], addr[3:0]}];
	always @(posedge clock) if (wr) mem[{dev[3:0], addr[3:0]}] <= wdata;
endmodule // gms_mmd_model
`default_nettype wire

// [gms_regs.v]
`timescale 1ns/1ps
`default_nettype none
`include "gms_map.vh"
module gms_regs #(
	parameter CNT_W = 8
) (
	input  wire        clock,
	input  wire        rstn,
	input  wire [4:0]  reg_addr,
	input  wire        reg_wr,
	input  wire        reg_rd,
	input  wire [15:0] reg_wdata,
	output reg  [15:0] reg_rdata_r,
	input  wire        auto_master,
	input  wire        ms_fault,
	input  wire        local_rx_ok,
	input  wire        remote_rx_ok,
	input  wire        lp_adv_fd,
	input  wire        lp_adv_hd,
	input  wire        idle_err,
	output reg  [2:0]  test_mode_r,
	output wire        is_master,
	output wire        adv_port_multi,
	output wire        adv_1000_fd,
	output wire        adv_1000_hd,
	output wire [4:0]  mmd_device_select,
	output wire [15:0] mmd_reg_addr,
	output wire        mmd_wr,
	output wire        mmd_rd,
	output wire [15:0] mmd_wdata,
	input  wire [15:0] mmd_rdata
);
	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	reg         man_en_r;
	reg         man_master_r;
	reg         port_type_r;
	reg         adv_fd_r;
	reg         adv_hd_r;
	reg         fault_r;
	reg  [1:0]  mmd_fn_r;
	reg  [4:0]  mmd_dev_r;
	reg  [15:0] mmd_addr_r;

	// ------------------------------------------------------------
	// next values
	// ------------------------------------------------------------
	reg  [2:0]  test_mode_nxt;
	reg         man_en_nxt;
	reg         man_master_nxt;
	reg         port_type_nxt;
	reg         adv_fd_nxt;
	reg         adv_hd_nxt;
	reg         fault_nxt;
	reg  [1:0]  mmd_fn_nxt;
	reg  [4:0]  mmd_dev_nxt;
	reg  [15:0] mmd_addr_nxt;
	reg  [15:0] reg_rdata_nxt;
	wire [CNT_W-1:0] idle_cnt;

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	// a read and a write in one cycle are not supported
	wire       hit_ctl  = reg_addr == `GMS_IDX_MS_CTRL;
	wire       hit_stat = reg_addr == `GMS_IDX_MS_STAT;
	wire       hit_mmdc = reg_addr == `GMS_IDX_MMD_CTRL;
	wire       hit_ad   = reg_addr == `GMS_IDX_MMD_ADDAT;
	wire       wr_ctl   = reg_wr && hit_ctl;
	wire       rd_stat  = reg_rd && hit_stat;
	wire       wr_mmdc  = reg_wr && hit_mmdc;
	wire       wr_ad    = reg_wr && hit_ad;
	wire       rd_ad    = reg_rd && hit_ad;
	wire       is_data  = mmd_fn_r != `GMS_FN_ADDR;
	wire [2:0] test_wr  = reg_wdata[`GMS_CTL_TEST_HI:`GMS_CTL_TEST_LO];
	wire [1:0] fn_wr    = reg_wdata[`GMS_MMD_FN_HI:`GMS_MMD_FN_LO];

	// ------------------------------------------------------------
	// gigabit control register
	// ------------------------------------------------------------
	// test mode select
	always @* begin
		test_mode_nxt = test_mode_r;
		if (wr_ctl) begin
			// reserved test codes fall back to normal operation
			if (test_wr > `GMS_TEST_MAX) begin
				test_mode_nxt = 3'h0;
			end else begin
				test_mode_nxt = test_wr;
			end
		end
	end

	always @* begin
		man_en_nxt     = man_en_r;
		man_master_nxt = man_master_r;
		if (wr_ctl) begin
			man_en_nxt     = reg_wdata[`GMS_CTL_MAN_EN];
			man_master_nxt = reg_wdata[`GMS_CTL_MAN_MASTER];
		end
	end

	always @* begin
		port_type_nxt = port_type_r;
		adv_fd_nxt    = adv_fd_r;
		adv_hd_nxt    = adv_hd_r;
		if (wr_ctl) begin
			port_type_nxt = reg_wdata[`GMS_CTL_PORT_TYPE];
			adv_fd_nxt    = reg_wdata[`GMS_CTL_ADV_FD];
			// stored as written; software keeps it zero
			adv_hd_nxt    = reg_wdata[`GMS_CTL_ADV_HD];
		end
	end

	// whole writable byte resets from one image
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			{test_mode_r, man_en_r, man_master_r, port_type_r, adv_fd_r, adv_hd_r} <=
				`GMS_CTL_RST;
		end else begin
			test_mode_r  <= test_mode_nxt;
			man_en_r     <= man_en_nxt;
			man_master_r <= man_master_nxt;
			port_type_r  <= port_type_nxt;
			adv_fd_r     <= adv_fd_nxt;
			adv_hd_r     <= adv_hd_nxt;
		end
	end

	assign is_master      = man_en_r ? man_master_r : auto_master;
	assign adv_port_multi = port_type_r;
	assign adv_1000_fd    = adv_fd_r;
	assign adv_1000_hd    = adv_hd_r;

	// ------------------------------------------------------------
	// latched fault and idle error count
	// ------------------------------------------------------------
	// latch high, clear on read
	always @* begin
		fault_nxt = fault_r;
		// a fault in the reading cycle wins, so none is lost
		if (ms_fault) begin
			fault_nxt = 1'b1;
		end else if (rd_stat) begin
			fault_nxt = 1'b0;
		end
	end

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fault_r <= 1'b0;
		end else begin
			fault_r <= fault_nxt;
		end
	end

	gms_sat_cnt #(
		.W       (CNT_W)
	) u_idle_cnt (
		.clock   (clock),
		.rstn    (rstn),
		.inc     (idle_err),
		.clr     (rd_stat),
		.count_r (idle_cnt)
	);

	// ------------------------------------------------------------
	// indirect mmd access
	// ------------------------------------------------------------
	// function and device select
	always @* begin
		mmd_fn_nxt  = mmd_fn_r;
		mmd_dev_nxt = mmd_dev_r;
		if (wr_mmdc) begin
			mmd_fn_nxt  = fn_wr;
			mmd_dev_nxt = reg_wdata[`GMS_MMD_DEV_HI:`GMS_MMD_DEV_LO];
		end
	end

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mmd_fn_r  <= `GMS_FN_ADDR;
			mmd_dev_r <= 5'h00;
		end else begin
			mmd_fn_r  <= mmd_fn_nxt;
			mmd_dev_r <= mmd_dev_nxt;
		end
	end

	// address write, post increment
	// the address wraps past its top, no carry is kept
	always @* begin
		mmd_addr_nxt = mmd_addr_r;
		case (mmd_fn_r)
		`GMS_FN_ADDR: begin
			if (wr_ad) begin
				mmd_addr_nxt = reg_wdata;
			end
		end
		`GMS_FN_INC_RW: begin
			if (wr_ad || rd_ad) begin
				mmd_addr_nxt = mmd_addr_r + 16'h0001;
			end
		end
		`GMS_FN_INC_WR: begin
			if (wr_ad) begin
				mmd_addr_nxt = mmd_addr_r + 16'h0001;
			end
		end
		default: begin
			mmd_addr_nxt = mmd_addr_r;
		end
		endcase
	end

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mmd_addr_r <= 16'h0000;
		end else begin
			mmd_addr_r <= mmd_addr_nxt;
		end
	end

	// data forwarded to selected mmd
	// strobes are combinational so the far side answers in the request cycle
	assign mmd_device_select = mmd_dev_r;
	assign mmd_reg_addr      = mmd_addr_r;
	assign mmd_wr            = wr_ad && is_data;
	assign mmd_rd            = rd_ad && is_data;
	assign mmd_wdata         = reg_wdata;

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	// reserved and unmapped read zero
	always @* begin
		// last read value stands until the next read
		reg_rdata_nxt = reg_rdata_r;
		if (reg_rd) begin
			case (reg_addr)
			`GMS_IDX_MS_CTRL: begin
				reg_rdata_nxt = {test_mode_r, man_en_r, man_master_r, port_type_r,
					adv_fd_r, adv_hd_r, 8'h00};
			end
			`GMS_IDX_MS_STAT: begin
				reg_rdata_nxt = {fault_r, is_master, local_rx_ok, remote_rx_ok,
					lp_adv_fd, lp_adv_hd, 2'b00, idle_cnt[7:0]};
			end
			`GMS_IDX_MMD_CTRL: begin
				reg_rdata_nxt = {mmd_fn_r, 9'h000, mmd_dev_r};
			end
			`GMS_IDX_MMD_ADDAT: begin
				reg_rdata_nxt = is_data ? mmd_rdata : mmd_addr_r;
			end
			`GMS_IDX_EXT_STAT: begin
				reg_rdata_nxt = `GMS_EXT_STAT_VAL;
			end
			default: begin
				reg_rdata_nxt = 16'h0000;
			end
			endcase
		end
	end

	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reg_rdata_r <= 16'h0000;
		end else begin
			reg_rdata_r <= reg_rdata_nxt;
		end
	end

endmodule // gms_regs
`default_nettype wire

// [gms_regs_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module gms_regs_sva (
	input wire logic        clock,
	input wire logic        rstn,
	input wire logic [4:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata_r,
	input wire logic [2:0]  test_mode_r,
	input wire logic        adv_1000_fd,
	input wire logic        mmd_wr,
	input wire logic        mmd_rd,
	input wire logic [15:0] mmd_wdata
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	property p_ext; reg_rd && reg_addr == 5'h0F |=> reg_rdata_r == 16'h2000; endproperty
	a_ext: assert property (p_ext) else $error("ext status wrong");
	property p_unm; reg_rd && reg_addr == 5'h05 |=> reg_rdata_r == 16'h0000; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_keep; !(reg_wr && reg_addr == 5'h09) |=> $stable({test_mode_r, adv_1000_fd}); endproperty
	a_keep: assert property (p_keep) else $error("control changed unwritten");
	property p_mwr; mmd_wr |-> reg_wr && reg_addr == 5'h0E; endproperty
	a_mwr: assert property (p_mwr) else $error("stray mmd write");
	property p_mwd; mmd_wr |-> mmd_wdata == reg_wdata; endproperty
	a_mwd: assert property (p_mwd) else $error("mmd write data wrong");
	property p_mrd; mmd_rd |-> reg_rd && reg_addr == 5'h0E; endproperty
	a_mrd: assert property (p_mrd) else $error("stray mmd read");
	property p_test; reg_wr && reg_addr == 5'h09 |=> test_mode_r ==
		($past(reg_wdata[15:13]) > 3'h4 ? 3'h0 : $past(reg_wdata[15:13])); endproperty
	a_test: assert property (p_test) else $error("test mode wrong");
	property p_fd; reg_wr && reg_addr == 5'h09 |=> adv_1000_fd == $past(reg_wdata[9]); endproperty
	a_fd: assert property (p_fd) else $error("full duplex advert wrong");
	c_mwr: cover property (mmd_wr);
	c_mrd: cover property (mmd_rd);
	c_bad: cover property (reg_wr && reg_addr == 5'h09 && reg_wdata[15:13] > 3'h4);
endmodule // gms_regs_sva
bind gms_regs gms_regs_sva u_sva (.clock, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
	.reg_rdata_r, .test_mode_r, .adv_1000_fd, .mmd_wr, .mmd_rd, .mmd_wdata);
`default_nettype wire

// [gms_sat_cnt.v]
`timescale 1ns/1ps
`default_nettype none
module gms_sat_cnt #(
	parameter W = 8
) (
	input  wire         clock,
	input  wire         rstn,
	input  wire         inc,
	input  wire         clr,
	output reg  [W-1:0] count_r
);
	// increment in the clearing cycle is kept, so no error is lost
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count_r <= {W{1'b0}};
		end else if (clr) begin
			count_r <= inc ? {{(W-1){1'b0}}, 1'b1} : {W{1'b0}};
		end else if (inc && count_r != {W{1'b1}}) begin
			count_r <= count_r + {{(W-1){1'b0}}, 1'b1};
		end
	end
endmodule // gms_sat_cnt
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        clock = 0, rstn = 0, reg_wr = 0, reg_rd = 0, ms_fault = 0, idle_err = 0;
	logic [4:0]  lv = 5'h00, reg_addr = 5'h00, dev = 5'h00;
	logic [15:0] reg_wdata = 16'h0000, adr = 16'h0000;
	wire  [15:0] reg_rdata_r, mmd_reg_addr, mmd_wdata, mmd_rdata;
	wire  [4:0]  mds;
	wire  [2:0]  tm;
	wire         is_m, apm, afd, ahd, mmd_wr, mmd_rd;
	logic [7:0]  ctl = 8'h02, cnt = 8'h00;
	logic [1:0]  fn = 2'h0;
	logic        flt = 0;
	logic [31:0] r;
	int          mm [256];
	int          failures = 0, n_checks = 0, seed = 32'hE491;
	logic [4:0]  tab [6] = '{5'h09, 5'h0A, 5'h0D, 5'h0E, 5'h0F, 5'h05};
	always #5 clock = ~clock;
	gms_regs DUT (.clock, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_r,
		.auto_master(lv[4]), .local_rx_ok(lv[3]), .remote_rx_ok(lv[2]), .lp_adv_fd(lv[1]),
		.lp_adv_hd(lv[0]), .ms_fault, .idle_err, .test_mode_r(tm), .is_master(is_m),
		.adv_port_multi(apm), .adv_1000_fd(afd), .adv_1000_hd(ahd), .mmd_device_select(mds),
		.mmd_reg_addr, .mmd_wr, .mmd_rd, .mmd_wdata, .mmd_rdata);
	gms_mmd_model u_mmd (.clock, .dev(mds), .addr(mmd_reg_addr), .wr(mmd_wr), .wdata(mmd_wdata),
		.rdata(mmd_rdata));
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(negedge clock);
		chk({15'h0000, mmd_wr}, {15'h0000, a == 5'h0E && fn != 2'h0});
		@(posedge clock);
		reg_wr <= 1'b0;
		if (a == 5'h09) ctl = (d[15:13] > 3'h4) ? {3'h0, d[12:8]} : d[15:8];
		if (a == 5'h0D) {fn, dev} = {d[15:14], d[4:0]};
		if (a == 5'h0E && fn == 2'h0) adr = d;
		if (a == 5'h0E && fn != 2'h0) mm[{dev[3:0], adr[3:0]}] = d;
		if (a == 5'h0E && fn[1]) adr = adr + 16'h0001;
	endtask
	task rd(input logic [4:0] a);
		logic [15:0] e;
		logic [4:0]  s;
		s = (a == 5'h0A) ? $random(seed) : lv;
		case (a)
			5'h09: e = {ctl, 8'h00};
			5'h0A: e = {flt, (ctl[4] ? ctl[3] : s[4]), s[3:0], 2'h0, cnt};
			5'h0D: e = {fn, 9'h000, dev};
			5'h0E: e = (fn == 2'h0) ? adr : 16'(mm[{dev[3:0], adr[3:0]}]);
			5'h0F: e = 16'h2000;
			default: e = 16'h0000;
		endcase
		@(posedge clock);
		{reg_addr, reg_rd, lv} <= {a, 1'b1, s};
		@(negedge clock);
		chk({15'h0000, mmd_rd}, {15'h0000, a == 5'h0E && fn != 2'h0});
		@(posedge clock);
		reg_rd <= 1'b0;
		if (a == 5'h0A) {flt, cnt} = 9'h000;
		if (a == 5'h0E && fn == 2'h2) adr = adr + 16'h0001;
		@(negedge clock);
		chk(reg_rdata_r, e);
		chk({4'h0, tm, apm, afd, ahd, is_m, mds}, {4'h0, ctl[7:5], ctl[2:0],
			(ctl[4] ? ctl[3] : lv[4]), dev});
		chk(mmd_reg_addr, adr);
	endtask
	task ev(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			{idle_err, ms_fault} <= {1'b1, i == 0};
		end
		@(posedge clock);
		{idle_err, ms_fault} <= 2'h0;
		{flt, cnt} = {1'b1, (cnt + n > 255) ? 8'hFF : 8'(cnt + n)};
	endtask
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		end_of_test;
	end
	initial begin
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		foreach (tab[i]) rd(tab[i]);
		ev(260);
		rd(5'h0A);
		rd(5'h0A);
		$display("reset and counter tests done");
		for (int k = 0; k < 400; k++) begin
			r = $random(seed);
			if (r[4:3] == 2'h3) wr(tab[r[10:8] % 6], r[31:16] & 16'hFEFF);
			else if (r[4:3] == 2'h0) ev(int'(r[7:5]) + 1);
			else rd(tab[r[10:8] % 6]);
		end
		$display("random test done");
		// mid-run reset restores every register
		@(posedge clock);
		rstn <= 1'b0;
		{ctl, fn, dev, adr, flt, cnt} = {8'h02, 2'h0, 5'h00, 16'h0000, 1'b0, 8'h00};
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		foreach (tab[i]) rd(tab[i]);
		$display("mid-run reset test done");
		end_of_test;
	end
endmodule // tb
`default_nettype wire
